// [dv/dtt_cpu_model.sv]
`timescale 1ns/1ps
// cpu core side: bus accesses, executed opcodes and change-of-flow events
module dtt_cpu_model (
  input  wire logic        i_mclk,
  output logic             o_bus_valid,
  output logic             o_bus_rnw,
  output logic [15:0]      o_bus_addr,
  output logic [7:0]       o_bus_data,
  output logic             o_exec,
  output logic [15:0]      o_exec_addr,
  output logic             o_cof,
  output logic [15:0]      o_cof_addr
);
  initial begin
    o_bus_valid = 1'b0;
    o_bus_rnw   = 1'b1;
    o_bus_addr  = 16'hFFFF;
    o_bus_data  = 8'hFF;
    o_exec      = 1'b0;
    o_exec_addr = 16'hFFFF;
    o_cof       = 1'b0;
    o_cof_addr  = 16'hFFFF;
  end

  ////////////////////////////////////////////////////////////////////////////
  // released address and data lines show the inverse so no stale value passes for a match
  task automatic access(input logic [15:0] a, input logic [7:0] d,
                        input logic rnw);
    @(posedge i_mclk);
    o_bus_valid <= 1'b1;
    o_bus_addr  <= a;
    o_bus_data  <= d;
    o_bus_rnw   <= rnw;
    @(posedge i_mclk);
    o_bus_valid <= 1'b0;
    o_bus_addr  <= ~a;
    o_bus_data  <= ~d;
  endtask

  task automatic exec(input logic [15:0] a);
    @(posedge i_mclk);
    o_exec      <= 1'b1;
    o_exec_addr <= a;
    @(posedge i_mclk);
    o_exec      <= 1'b0;
    o_exec_addr <= ~a;
  endtask

  task automatic cof(input logic [15:0] a);
    @(posedge i_mclk);
    o_cof      <= 1'b1;
    o_cof_addr <= a;
    @(posedge i_mclk);
    o_cof      <= 1'b0;
    o_cof_addr <= ~a;
  endtask
endmodule

// [dv/tb_dtt_top.sv]
`timescale 1ns/1ps
module tb_dtt_top
  import dtt_pkg::*;
;
  typedef struct packed {
    logic [3:0]  m;
    logic [15:0] b;
    logic [15:0] a;
    logic [7:0]  d;
    logic        t;
  } dtt_case_t;

  logic        i_mclk = 1'b0;
  logic        i_nrst = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_secure = 1'b0;
  logic [7:0]  o_rdata;
  logic        bus_valid, bus_rnw, exec, cof;
  logic [15:0] bus_addr, exec_addr, cof_addr;
  logic [7:0]  bus_data;
  logic        o_break_req, o_break_tag, o_armed;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  dtt_case_t   cases [17] = '{
    '{4'h0, 16'h2000, 16'h1000, 8'h00, 1'b1},
    '{4'h0, 16'h2000, 16'h2000, 8'h00, 1'b0},
    '{4'h1, 16'h2000, 16'h2000, 8'h00, 1'b1},
    '{4'h1, 16'h2000, 16'h3000, 8'h00, 1'b0},
    '{4'h2, 16'h2000, 16'h2000, 8'h00, 1'b0},
    '{4'h3, 16'h2000, 16'h2000, 8'h11, 1'b0},
    '{4'h4, 16'h2000, 16'h2000, 8'h11, 1'b0},
    '{4'h5, 16'h0055, 16'h1000, 8'h55, 1'b1},
    '{4'h5, 16'h0055, 16'h1000, 8'h54, 1'b0},
    '{4'h6, 16'h0055, 16'h1000, 8'h54, 1'b1},
    '{4'h6, 16'h0055, 16'h1000, 8'h55, 1'b0},
    '{4'h7, 16'h2000, 16'h2000, 8'h00, 1'b1},
    '{4'h7, 16'h2000, 16'h2001, 8'h00, 1'b0},
    '{4'h8, 16'h2000, 16'h0FFF, 8'h00, 1'b1},
    '{4'h8, 16'h2000, 16'h1000, 8'h00, 1'b0},
    '{4'h9, 16'h2000, 16'h1000, 8'h00, 1'b0},
    '{4'hF, 16'h2000, 16'h1000, 8'h00, 1'b0}};

  always #2 i_mclk = ~i_mclk;

  dtt_cpu_model u_dtt_cpu_model (
    .i_mclk(i_mclk), .o_bus_valid(bus_valid), .o_bus_rnw(bus_rnw),
    .o_bus_addr(bus_addr), .o_bus_data(bus_data), .o_exec(exec),
    .o_exec_addr(exec_addr), .o_cof(cof), .o_cof_addr(cof_addr));

  dtt_top u_dtt_top (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_bus_valid(bus_valid), .i_bus_rnw(bus_rnw),
    .i_bus_addr(bus_addr), .i_bus_data(bus_data), .i_exec(exec),
    .i_exec_addr(exec_addr), .i_cof(cof), .i_cof_addr(cof_addr),
    .i_secure(i_secure), .o_break_req(o_break_req),
    .o_break_tag(o_break_tag), .o_armed(o_armed));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the read edge
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd   <= 1'b0;
    #1 chk8(o_rdata, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(DTT_OFS_CTRL, DTT_CTRL_RST);
    rdchk(DTT_OFS_TRIG, DTT_TRIG_RST);
    rdchk(DTT_OFS_STATUS, 8'h00);
    rdchk(DTT_OFS_CMPA_HI, 8'h00);
    chk1(o_armed, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_trig_lock();
    wr(DTT_OFS_TRIG, 8'hFF);
    rdchk(DTT_OFS_TRIG, 8'hCF);
    wr(DTT_OFS_CTRL, 8'hC0);
    wr(DTT_OFS_TRIG, 8'h00);
    rdchk(DTT_OFS_TRIG, 8'hCF);
    wr(DTT_OFS_CTRL, 8'h00);
    #1 chk1(o_armed, 1'b0);
    wr(DTT_OFS_STATUS, 8'hFF);
    rdchk(DTT_OFS_STATUS, 8'h00);
    rdchk(4'hF, 8'h00);
    $display("test trig_lock done");
  endtask

  task automatic t_secure();
    @(posedge i_mclk);
    i_secure <= 1'b1;
    wr(DTT_OFS_CTRL, 8'hC0);
    #1 chk1(o_armed, 1'b0);
    rdchk(DTT_OFS_CTRL, 8'h00);
    @(posedge i_mclk);
    i_secure <= 1'b0;
    $display("test secure done");
  endtask

  task automatic t_end_break();
    wr(DTT_OFS_CMPA_HI, 8'h10);
    wr(DTT_OFS_CMPA_LO, 8'h00);
    wr(DTT_OFS_TRIG, 8'h00);
    wr(DTT_OFS_CTRL, 8'hD0);
    #1 chk1(o_armed, 1'b1);
    u_dtt_cpu_model.access(16'h1000, 8'h00, 1'b1);
    #1 chk1(o_break_req, 1'b1);
    chk1(o_armed, 1'b0);
    @(posedge i_mclk);
    #1 chk1(o_break_req, 1'b0);
    rdchk(DTT_OFS_STATUS, 8'h80);
    $display("test end_break done");
  endtask

  task automatic t_tag();
    wr(DTT_OFS_TRIG, 8'h80);
    wr(DTT_OFS_CTRL, 8'hF0);
    #1 chk1(o_break_tag, 1'b1);
    u_dtt_cpu_model.access(16'h1000, 8'h00, 1'b1);
    repeat (2) @(posedge i_mclk);
    #1 chk1(o_armed, 1'b1);
    u_dtt_cpu_model.exec(16'h1000);
    repeat (2) @(posedge i_mclk);
    #1 chk1(o_armed, 1'b0);
    wr(DTT_OFS_CTRL, 8'h00);
    $display("test tag done");
  endtask

  task automatic t_modes();
    foreach (cases[i]) begin
      wr(DTT_OFS_CMPB_HI, cases[i].b[15:8]);
      wr(DTT_OFS_CMPB_LO, cases[i].b[7:0]);
      wr(DTT_OFS_TRIG, {4'h0, cases[i].m});
      wr(DTT_OFS_CTRL, 8'hC0);
      u_dtt_cpu_model.access(cases[i].a, cases[i].d, 1'b1);
      repeat (2) @(posedge i_mclk);
      #1 chk1(o_armed, !cases[i].t);
      wr(DTT_OFS_CTRL, 8'h00);
    end
    $display("test modes done");
  endtask

  task automatic t_event_fill();
    wr(DTT_OFS_CMPB_HI, 8'h20);
    wr(DTT_OFS_CMPB_LO, 8'h00);
    wr(DTT_OFS_TRIG, 8'h03);
    wr(DTT_OFS_CTRL, 8'hC0);
    for (int i = 0; i < 8; i++) begin
      u_dtt_cpu_model.access(16'h2000, 8'(8'h10 + i), 1'b0);
      if (i == 6) begin
        #1 chk1(o_armed, 1'b1);
      end
    end
    repeat (2) @(posedge i_mclk);
    #1 chk1(o_armed, 1'b0);
    rdchk(DTT_OFS_STATUS, 8'h48);
    // host keeps its own count of words taken out
    for (int n = 0; n < 8; n++) begin
      rdchk(DTT_OFS_FIFO_HI, DTT_ZERO8);
      rdchk(DTT_OFS_FIFO_LO, 8'(8'h10 + n));
    end
    rdchk(DTT_OFS_STATUS, 8'h48);
    $display("test event_fill done");
  endtask

  task automatic t_manual_stop();
    wr(DTT_OFS_TRIG, 8'h00);
    wr(DTT_OFS_CTRL, 8'hC0);
    rdchk(DTT_OFS_STATUS, 8'h20);
    for (int i = 0; i < 3; i++) begin
      u_dtt_cpu_model.cof(16'(16'h4000 + i));
    end
    wr(DTT_OFS_CTRL, 8'h80);
    #1 chk1(o_armed, 1'b0);
    rdchk(DTT_OFS_STATUS, 8'h03);
    $display("test manual_stop done");
  endtask

  // A then B begin trace: B before A ignored, no storing before trigger
  task automatic t_begin_seq();
    wr(DTT_OFS_TRIG, 8'h42);
    wr(DTT_OFS_CTRL, 8'hD0);
    u_dtt_cpu_model.access(16'h2000, 8'h00, 1'b1);
    rdchk(DTT_OFS_STATUS, 8'h20);
    u_dtt_cpu_model.access(16'h1000, 8'h00, 1'b1);
    u_dtt_cpu_model.cof(16'h5000);
    u_dtt_cpu_model.access(16'h2000, 8'h00, 1'b1);
    rdchk(DTT_OFS_STATUS, 8'hE0);
    for (int k = 0; k < 8; k++) begin
      u_dtt_cpu_model.cof(16'(16'h4100 + k));
    end
    @(posedge i_mclk);
    #1 chk1(o_break_req, 1'b1);
    chk1(o_armed, 1'b0);
    u_dtt_cpu_model.cof(16'h4F00);
    rdchk(DTT_OFS_STATUS, 8'hC8);
    for (int n = 0; n < 8; n++) begin
      rdchk(DTT_OFS_FIFO_HI, 8'h41);
      rdchk(DTT_OFS_FIFO_LO, 8'(n));
    end
    $display("test begin_seq done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge i_mclk);
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge i_mclk);
    i_nrst <= 1'b1;
    t_reset();
    t_trig_lock();
    t_secure();
    t_end_break();
    t_tag();
    t_modes();
    t_event_fill();
    t_manual_stop();
    t_begin_seq();
    summarize();
  end
endmodule

// [hdl/dtt_comparator.sv]
`timescale 1ns/1ps
module dtt_comparator
  import dtt_pkg::*;
(
  dtt_cmp_if.cmp c
);
  logic qual;

  // r/w level only counts when its enable is set; 1 means read
  assign qual = c.valid & (~c.rw_en | (c.rnw == c.rw_val));
  assign c.eq = qual & (c.val == c.ref_val);
  assign c.lt = qual & (c.val < c.ref_val);
  assign c.gt = qual & (c.val > c.ref_val);
endmodule

// [hdl/dtt_fifo.sv]
`timescale 1ns/1ps
module dtt_fifo
  import dtt_pkg::*;
#(
  parameter int unsigned DEPTH = DTT_FIFO_DEPTH,
  parameter int unsigned W     = DTT_FIFO_W,
  parameter int unsigned CW    = DTT_CNT_W
)(
  input  wire logic          i_mclk,
  input  wire logic          i_nrst,
  input  wire logic          i_clear,
  input  wire logic          i_push,
  input  wire logic [W-1:0]  i_data,
  input  wire logic          i_pop,
  output logic      [W-1:0]  o_head,
  output logic      [CW-1:0] o_count,
  output logic               o_full
);
  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [CW-1:0]           cnt;
  } dtt_fifo_st_t;

  dtt_fifo_st_t s_q;
  dtt_fifo_st_t s_d;
  logic [PW-1:0] rp;

  assign o_full  = (s_q.cnt == CW'(DEPTH));
  assign o_count = s_q.cnt;
  assign rp      = s_q.wp - s_q.cnt[PW-1:0];
  assign o_head  = s_q.mem[rp];

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    if (i_clear) begin
      s_d.wp  = '0;
      s_d.cnt = '0;
    end else if (i_push) begin
      // when full the oldest word is overwritten: circular capture
      s_d.mem[s_q.wp] = i_data;
      s_d.wp          = s_q.wp + PW'(1);
      if (!o_full) begin
        s_d.cnt = s_q.cnt + CW'(1);
      end
    end else if (i_pop && s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - CW'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// [hdl/dtt_top.sv]
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
// How it works
// - trigger_config always readable, writable only unarmed; bits 5:4 zero
// - type bit set: matches count only when the opcode there executes
// - begin bit 0 fills circularly until trigger; 1 trigger starts storing
// - event-only modes ignore the begin bit and always run begin traces
// - modes 0000 A, 0001 A or B, 0010 A then B, 0011 event B, 0100 A then event B
// - 0101 A with B data match, 0110 A without it; B compares data
// - 0111 inside range, 1000 outside range, 1001 to 1111 never trigger
// - match-A flag clears at run start, sets on A match while armed
// - match-B flag clears at run start, sets on B match while armed
// - arm status mirrors arm control while the module is enabled
// - run ends on full FIFO in begin trace, on trigger in end trace
// - writing 0 to arm or enable ends the run at once
// - valid count clears at start and holds words valid at run end
// - valid count holds its value while the host reads words out
// - run_status is read-only; writes change nothing
// - event modes store a byte only; the high read returns zero
// - with breaks enabled, break on trigger (end) or on full (begin)
// - module enable cannot be set while the chip is secure
module dtt_top
  import dtt_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_bus_valid,
  input  wire logic        i_bus_rnw,
  input  wire logic [15:0] i_bus_addr,
  input  wire logic [7:0]  i_bus_data,
  input  wire logic        i_exec,
  input  wire logic [15:0] i_exec_addr,
  input  wire logic        i_cof,
  input  wire logic [15:0] i_cof_addr,
  input  wire logic        i_secure,
  output logic             o_break_req,
  output logic             o_break_tag,
  output logic             o_armed
);
  dtt_state_t s_q;
  dtt_state_t s_d;

  dtt_cmp_if #(.W(DTT_AW)) ca ();
  dtt_cmp_if #(.W(DTT_AW)) cb ();

  logic        armed;
  logic        full_mode;
  logic        ev_mode;
  logic        begin_tr;
  logic        ma;
  logic        mb;
  logic        b_data;
  logic        trig;
  logic        start;
  logic        stop;
  logic        wr_ctrl;
  logic        w_en;
  logic        f_push;
  logic        f_pop;
  logic        f_full;
  logic [15:0] f_data;
  logic [15:0] f_head;
  logic [3:0]  f_count;
  logic [15:0] use_addr;
  logic        use_valid;
  dtt_mode_t   mode;

  assign mode      = dtt_mode_t'(s_q.trig[3:0]);
  assign armed     = (s_q.run != DTT_R_IDLE);
  assign full_mode = (mode == DTT_M_A_AND_D) || (mode == DTT_M_A_NOT_D);
  assign ev_mode   = (mode == DTT_M_EV_B) || (mode == DTT_M_A_EV_B);
  assign begin_tr  = s_q.trig[DTT_T_BEGIN] | ev_mode;

  ////////////////////////////////////////////////////////////////////////
  // comparators: tag type looks at executed opcodes, force at any access
  assign use_addr  = s_q.trig[DTT_T_SEL] ? i_exec_addr : i_bus_addr;
  assign use_valid = s_q.trig[DTT_T_SEL] ? i_exec : i_bus_valid;

  assign ca.ref_val = s_q.cmp_a;
  assign ca.val     = use_addr;
  assign ca.valid   = use_valid;
  assign ca.rnw     = s_q.trig[DTT_T_SEL] | i_bus_rnw;
  assign ca.rw_en   = s_q.ctrl[DTT_C_RWAEN];
  assign ca.rw_val  = s_q.ctrl[DTT_C_RWA];

  assign cb.ref_val = full_mode ? {DTT_ZERO8, s_q.cmp_b[7:0]} : s_q.cmp_b;
  assign cb.val     = full_mode ? {DTT_ZERO8, i_bus_data} : use_addr;
  assign cb.valid   = full_mode ? i_bus_valid : use_valid;
  assign cb.rnw     = full_mode ? i_bus_rnw
                                : (s_q.trig[DTT_T_SEL] | i_bus_rnw);
  assign cb.rw_en   = s_q.ctrl[DTT_C_RWBEN];
  assign cb.rw_val  = s_q.ctrl[DTT_C_RWB];

  dtt_comparator u_cmp_a (
    .c (ca.cmp)
  );
  dtt_comparator u_cmp_b (
    .c (cb.cmp)
  );

  assign ma     = ca.eq;
  assign b_data = cb.eq;
  // B ignored until A has matched in sequential modes
  assign mb = cb.eq & (((mode != DTT_M_A_THEN) && (mode != DTT_M_A_EV_B))
                       | s_q.seq_a | ma);

  ////////////////////////////////////////////////////////////////////////
  // trigger selection
  always_comb begin
    case (mode)
      DTT_M_A:       trig = ma;
      DTT_M_A_OR_B:  trig = ma | mb;
      DTT_M_A_THEN:  trig = mb;
      DTT_M_EV_B:    trig = mb;
      DTT_M_A_EV_B:  trig = mb;
      DTT_M_A_AND_D: trig = ma & b_data;
      DTT_M_A_NOT_D: trig = ma & ~b_data;
      DTT_M_INSIDE:  trig = (ca.eq | ca.gt) & (cb.eq | cb.lt);
      DTT_M_OUTSIDE: trig = ca.lt | cb.gt;
      default:       trig = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // run control
  assign wr_ctrl = i_wr && (i_addr == DTT_OFS_CTRL);
  assign w_en    = i_wdata[DTT_C_EN] & ~i_secure;
  assign start   = wr_ctrl & w_en & i_wdata[DTT_C_ARM] & ~armed;
  assign stop    = wr_ctrl & ~(w_en & i_wdata[DTT_C_ARM]);
  assign f_pop   = i_rd && (i_addr == DTT_OFS_FIFO_LO) && !armed;
  assign f_data  = ev_mode ? {DTT_ZERO8, i_bus_data} : i_cof_addr;
  always_comb begin
    case (s_q.run)
      DTT_R_END:   f_push = i_cof;
      DTT_R_STORE: f_push = (ev_mode ? mb : i_cof) & ~f_full;
      default:     f_push = 1'b0;
    endcase
  end

  dtt_fifo #(
    .DEPTH (DTT_FIFO_DEPTH),
    .W     (DTT_FIFO_W),
    .CW    (DTT_CNT_W)
  ) u_fifo (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_clear (start),
    .i_push  (f_push),
    .i_data  (f_data),
    .i_pop   (f_pop),
    .o_head  (f_head),
    .o_count (f_count),
    .o_full  (f_full)
  );

  always_comb begin
    s_d     = s_q;
    s_d.brk = 1'b0;
    if (armed && ma) begin
      s_d.af    = 1'b1;
      s_d.seq_a = 1'b1;
    end
    if (armed && mb) begin
      s_d.bf = 1'b1;
    end
    case (s_q.run)
      DTT_R_END: begin
        if (trig) begin
          s_d.run = DTT_R_IDLE;
          s_d.brk = s_q.ctrl[DTT_C_BRK];
          s_d.cnt = f_count;
        end
      end
      DTT_R_WAIT: begin
        if (trig) begin
          s_d.run = DTT_R_STORE;
        end
      end
      DTT_R_STORE: begin
        if (f_full) begin
          s_d.run = DTT_R_IDLE;
          s_d.brk = s_q.ctrl[DTT_C_BRK];
          s_d.cnt = f_count;
        end
      end
      default: begin
      end
    endcase
    if (i_wr) begin
      case (i_addr)
        DTT_OFS_CMPA_HI: s_d.cmp_a[15:8] = i_wdata;
        DTT_OFS_CMPA_LO: s_d.cmp_a[7:0]  = i_wdata;
        DTT_OFS_CMPB_HI: s_d.cmp_b[15:8] = i_wdata;
        DTT_OFS_CMPB_LO: s_d.cmp_b[7:0]  = i_wdata;
        DTT_OFS_CTRL: begin
          s_d.ctrl          = i_wdata;
          s_d.ctrl[DTT_C_EN] = w_en;
        end
        DTT_OFS_TRIG: begin
          if (!armed) begin
            s_d.trig = i_wdata & DTT_T_WMASK;
          end
        end
        default: begin
        end
      endcase
    end
    if (stop && armed) begin
      s_d.run = DTT_R_IDLE;
      s_d.cnt = f_count;
    end
    if (start) begin
      s_d.af    = 1'b0;
      s_d.bf    = 1'b0;
      s_d.cnt   = '0;
      s_d.seq_a = 1'b0;
      if (ev_mode) begin
        s_d.run = DTT_R_STORE;
      end else if (s_q.trig[DTT_T_BEGIN]) begin
        s_d.run = DTT_R_WAIT;
      end else begin
        s_d.run = DTT_R_END;
      end
    end
    s_d.ctrl[DTT_C_ARM] = (s_d.run != DTT_R_IDLE);
    s_d.rdata = DTT_ZERO8;
    if (i_rd) begin
      case (i_addr)
        DTT_OFS_CMPA_HI: s_d.rdata = s_q.cmp_a[15:8];
        DTT_OFS_CMPA_LO: s_d.rdata = s_q.cmp_a[7:0];
        DTT_OFS_CMPB_HI: s_d.rdata = s_q.cmp_b[15:8];
        DTT_OFS_CMPB_LO: s_d.rdata = s_q.cmp_b[7:0];
        DTT_OFS_FIFO_HI: s_d.rdata = ev_mode ? DTT_ZERO8 : f_head[15:8];
        DTT_OFS_FIFO_LO: s_d.rdata = f_head[7:0];
        DTT_OFS_CTRL:    s_d.rdata = s_q.ctrl;
        DTT_OFS_TRIG:    s_d.rdata = s_q.trig;
        DTT_OFS_STATUS: begin
          // writes to this index fall through the write case: read-only
          s_d.rdata[DTT_S_AF]   = s_q.af;
          s_d.rdata[DTT_S_BF]   = s_q.bf;
          s_d.rdata[DTT_S_ARM_STATUS] = armed & s_q.ctrl[DTT_C_EN];
          s_d.rdata[3:0]        = s_q.cnt;
        end
        default: s_d.rdata = DTT_ZERO8;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      s_q       <= '0;
      s_q.cmp_a <= DTT_CMP_RST;
      s_q.cmp_b <= DTT_CMP_RST;
      s_q.ctrl  <= DTT_CTRL_RST;
      s_q.trig  <= DTT_TRIG_RST;
      s_q.run   <= DTT_R_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata     = s_q.rdata;
  assign o_break_req = s_q.brk;
  assign o_break_tag = s_q.ctrl[DTT_C_TAG];
  assign o_armed     = armed;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb_main @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  a_cfg_locked: assert property (
    i_wr && i_addr == DTT_OFS_TRIG && armed |=> $stable(s_q.trig))
    else $error("trigger_config written while armed");
  a_cfg_zero_bits: assert property (
    s_q.trig[5:4] == 2'b00)
    else $error("trigger_config bits 5:4 not zero");
  a_mode_none: assert property (
    s_q.trig[3] && s_q.trig[2:0] != 3'b000 |-> !trig)
    else $error("trigger in no-trigger mode");
  a_start_clear: assert property (
    start |=> !s_q.af && !s_q.bf && s_q.cnt == 4'h0 && armed)
    else $error("run start did not clear");
  a_flag_a_set: assert property (
    armed && ma && !start && !stop |=> s_q.af)
    else $error("match-A flag not set");
  a_arm_status: assert property (
    i_rd && i_addr == DTT_OFS_STATUS
    |=> o_rdata[DTT_S_ARM_STATUS] == $past(armed && s_q.ctrl[DTT_C_EN]))
    else $error("arm status mismatch");
  a_end_trace: assert property (
    s_q.run == DTT_R_END && trig && !start
    |=> !armed && o_break_req == $past(s_q.ctrl[DTT_C_BRK]))
    else $error("end trace did not end on trigger");
  a_full_end: assert property (
    s_q.run == DTT_R_STORE && f_full && !start
    |=> !armed && s_q.cnt == 4'h8)
    else $error("begin trace not ended");
  a_manual_stop: assert property (
    stop |=> !armed)
    else $error("run not stopped by write");
  a_count_hold: assert property (
    !armed && !start |=> $stable(s_q.cnt))
    else $error("valid count changed while idle");
  a_status_ro: assert property (
    i_wr && i_addr == DTT_OFS_STATUS && !armed
    |=> $stable({s_q.af, s_q.bf, s_q.cnt}))
    else $error("status written");
  a_high_zero: assert property (
    i_rd && i_addr == DTT_OFS_FIFO_HI && ev_mode |=> o_rdata == 8'h00)
    else $error("high read not zero");
  a_secure_en: assert property (
    i_secure && wr_ctrl |=> !s_q.ctrl[DTT_C_EN])
    else $error("enable set while secure");
  a_seq_b: assert property (
    mode == DTT_M_A_THEN && !s_q.seq_a && !ma |-> !trig)
    else $error("B accepted before A");

  c_end_run:   cover property (s_q.run == DTT_R_END ##1 !armed);
  c_begin_run: cover property (s_q.run == DTT_R_WAIT ##1
                               s_q.run == DTT_R_STORE);
  c_fifo_full: cover property (s_q.run == DTT_R_STORE && f_full);
  c_break:     cover property (o_break_req);
endmodule

// [include/dtt_cmp_if.sv]
`timescale 1ns/1ps
interface dtt_cmp_if #(parameter int unsigned W = 16);
  logic [W-1:0] ref_val;
  logic [W-1:0] val;
  logic         valid;
  logic         rnw;
  logic         rw_en;
  logic         rw_val;
  logic         eq;
  logic         lt;
  logic         gt;
  modport cmp  (input ref_val, val, valid, rnw, rw_en, rw_val,
                output eq, lt, gt);
  modport user (output ref_val, val, valid, rnw, rw_en, rw_val,
                input eq, lt, gt);
endinterface

// [include/dtt_pkg.sv]
package dtt_pkg;

  localparam int unsigned DTT_AW         = 16;
  localparam int unsigned DTT_DW         = 8;
  localparam int unsigned DTT_FIFO_DEPTH = 8;
  localparam int unsigned DTT_FIFO_W     = 16;
  localparam int unsigned DTT_CNT_W      = 4;

  // register index on the local register port
  localparam logic [3:0] DTT_OFS_CMPA_HI = 4'h0;
  localparam logic [3:0] DTT_OFS_CMPA_LO = 4'h1;
  localparam logic [3:0] DTT_OFS_CMPB_HI = 4'h2;
  localparam logic [3:0] DTT_OFS_CMPB_LO = 4'h3;
  localparam logic [3:0] DTT_OFS_FIFO_HI = 4'h4;
  localparam logic [3:0] DTT_OFS_FIFO_LO = 4'h5;
  localparam logic [3:0] DTT_OFS_CTRL    = 4'h6;
  localparam logic [3:0] DTT_OFS_TRIG    = 4'h7;
  localparam logic [3:0] DTT_OFS_STATUS  = 4'h8;

  // debug_control fields
  localparam int DTT_C_EN    = 7;
  localparam int DTT_C_ARM   = 6;
  localparam int DTT_C_TAG   = 5;
  localparam int DTT_C_BRK   = 4;
  localparam int DTT_C_RWA   = 3;
  localparam int DTT_C_RWAEN = 2;
  localparam int DTT_C_RWB   = 1;
  localparam int DTT_C_RWBEN = 0;
  // trigger_config fields
  localparam int DTT_T_SEL   = 7;
  localparam int DTT_T_BEGIN = 6;
  localparam logic [7:0] DTT_T_WMASK = 8'hCF;
  // run_status fields
  localparam int DTT_S_AF    = 7;
  localparam int DTT_S_BF    = 6;
  localparam int DTT_S_ARM_STATUS  = 5;

  localparam logic [7:0]  DTT_CTRL_RST = 8'h00;
  localparam logic [7:0]  DTT_TRIG_RST = 8'h00;
  localparam logic [15:0] DTT_CMP_RST  = 16'h0000;
  localparam logic [7:0]  DTT_ZERO8    = 8'h00;

  typedef enum logic [3:0] {
    DTT_M_A       = 4'b0000,
    DTT_M_A_OR_B  = 4'b0001,
    DTT_M_A_THEN  = 4'b0010,
    DTT_M_EV_B    = 4'b0011,
    DTT_M_A_EV_B  = 4'b0100,
    DTT_M_A_AND_D = 4'b0101,
    DTT_M_A_NOT_D = 4'b0110,
    DTT_M_INSIDE  = 4'b0111,
    DTT_M_OUTSIDE = 4'b1000
  } dtt_mode_t;

  typedef enum logic [1:0] {
    DTT_R_IDLE  = 2'b00,
    DTT_R_END   = 2'b01,
    DTT_R_WAIT  = 2'b10,
    DTT_R_STORE = 2'b11
  } dtt_run_t;

  typedef struct packed {
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [7:0]  ctrl;
    logic [7:0]  trig;
    dtt_run_t    run;
    logic        af;
    logic        bf;
    logic [3:0]  cnt;
    logic        seq_a;
    logic        brk;
    logic [7:0]  rdata;
  } dtt_state_t;

endpackage
